// [hdl/usb_ep_responder.sv]
/*
  Endpoint response logic of the usb_serial_engine: per-endpoint modes,
  automatic mode rewrites, PID flags, packet checks and the endpoint-zero
  interlock. Assumes token and packet strobes come from serial logic on
  CLK_IN, and that the CPU port is driven on the same clock.
*/
// Function
// - Disabled mode ignores all tokens
// - Mode 0001 accepts Setup, NAKs In/Out
// - Control modes 0010/0011/0100/0110 answer per table
// - Isochronous modes ignore Setup, stream data
// - 1001 acks Out then becomes 1000
// - 1011 acks Out then becomes 1010
// - 1101 sends count, after ACK 1100
// - 1111 sends count, after ACK 1110
// - Reset to disabled; stays until firmware writes
// - Accepted Setup forces mode 0001
// - Accepted Setup is answered with ACK
// - Status check wants zero length, toggle 1
// - Three PID flags per endpoint
// - Invalid transactions silently ignored
// - Interrupt on completion or buffer corruption
// - Valid data is at most 8 bytes (10 with CRC)
// - Non-control modes ignore Setup
// - Out endpoints ignore In, and reverse
// - In/Out flags update at transaction end
// - Setup flag updates at data start
// - ACK transaction locks endpoint-zero registers
// - CPU read after completion unlocks them
`timescale 1ns/10ps
module usb_ep_responder (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TOKEN_VALID_IN,
  input wire logic [1:0] TOKEN_PID_IN,
  input wire logic [1:0] TOKEN_EP_IN,
  input wire logic DATA_START_IN,
  input wire logic DATA_DONE_IN,
  input wire logic [3:0] DATA_COUNT_IN,
  input wire logic DATA_TOGGLE_IN,
  input wire logic DATA_ERR_IN,
  input wire logic HOST_ACK_IN,
  input wire logic TIMEOUT_IN,
  input wire logic BUF_CORRUPT_IN,
  input wire logic [1:0] CPU_EP_IN,
  input wire logic CPU_MODE_WR_IN,
  input wire logic CPU_COUNT_WR_IN,
  input wire logic [3:0] CPU_WDATA_IN,
  input wire logic CPU_RD_IN,
  output logic RESP_VALID_OUT,
  output logic [2:0] RESP_KIND_OUT,
  output logic [3:0] RESP_LEN_OUT,
  output logic [3:0] CPU_MODE_OUT,
  output logic [3:0] CPU_COUNT_OUT,
  output logic [8:0] PID_FLAGS_OUT,
  output logic [2:0] EP_IRQ_OUT,
  output logic EP0_LOCK_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  usb_ep_pkg::state_e st_q, st_d;
  logic [1:0] ep_q, ep_d, ev_ep;
  usb_ep_pkg::pid_e pid_q, pid_d;
  usb_ep_pkg::act_e act_q, act_d;
  logic [3:0] next_q, next_d;
  logic [3:0] mode_q [usb_ep_pkg::NUM_EP];
  logic [3:0] mode_d [usb_ep_pkg::NUM_EP];
  logic [3:0] count_q [usb_ep_pkg::NUM_EP];
  logic [3:0] count_d [usb_ep_pkg::NUM_EP];
  logic [2:0] flags_q [usb_ep_pkg::NUM_EP];
  logic [2:0] flags_d [usb_ep_pkg::NUM_EP];
  logic lock_q, lock_d;
  logic resp_v_q, resp_v_d;
  usb_ep_pkg::resp_e resp_k_q, resp_k_d;
  logic [3:0] resp_len_q, resp_len_d;
  logic [3:0] rd_mode_q, rd_mode_d, rd_count_q, rd_count_d;
  logic [2:0] irq_q, irq_d;
  logic done, ack_xfer, rx_ok, tok_ok, cpu_ok, cpu_locked;

  ep_decode_if dec ();

  ep_mode_decoder u_dec (
    .dec(dec.decoder)
  );

  function automatic logic ep_exists(input logic [1:0] ep);
    ep_exists = ({30'h0, ep} < usb_ep_pkg::NUM_EP);
  endfunction

  assign tok_ok = TOKEN_VALID_IN && ep_exists(TOKEN_EP_IN);
  assign cpu_ok = ep_exists(CPU_EP_IN);
  assign cpu_locked = lock_q && (CPU_EP_IN == usb_ep_pkg::LOCK_EP);
  assign dec.mode = tok_ok ? mode_q[TOKEN_EP_IN] : usb_ep_pkg::MODE_DISABLED;
  assign dec.pid = usb_ep_pkg::pid_e'(TOKEN_PID_IN);
  // Length counts the CRC, so an empty packet is two bytes
  assign rx_ok = !DATA_ERR_IN && (DATA_COUNT_IN <= usb_ep_pkg::MAX_RX_LEN);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    ep_d = ep_q;
    pid_d = pid_q;
    act_d = act_q;
    next_d = next_q;
    mode_d = mode_q;
    count_d = count_q;
    flags_d = flags_q;
    lock_d = lock_q;
    resp_v_d = 1'b0;
    resp_k_d = usb_ep_pkg::HS_NONE;
    resp_len_d = resp_len_q;
    rd_mode_d = rd_mode_q;
    rd_count_d = rd_count_q;
    irq_d = 3'h0;
    done = 1'b0;
    ack_xfer = 1'b0;
    ev_ep = ep_q;
    // CPU first so that engine updates below take precedence
    if (cpu_ok && !cpu_locked) begin
      if (CPU_MODE_WR_IN) begin
        mode_d[CPU_EP_IN] = CPU_WDATA_IN;
      end
      if (CPU_COUNT_WR_IN) begin
        count_d[CPU_EP_IN] = CPU_WDATA_IN;
      end
    end
    if (CPU_RD_IN && cpu_ok) begin
      rd_mode_d = mode_q[CPU_EP_IN];
      rd_count_d = count_q[CPU_EP_IN];
      // A read during a transaction must not open the lock early
      if (CPU_EP_IN == usb_ep_pkg::LOCK_EP && st_q == usb_ep_pkg::ST_IDLE) begin
        lock_d = 1'b0;
      end
    end
    unique case (st_q)
      usb_ep_pkg::ST_IDLE: begin
        if (tok_ok) begin
          ev_ep = TOKEN_EP_IN;
          ep_d = TOKEN_EP_IN;
          pid_d = dec.pid;
          act_d = dec.act;
          next_d = dec.next_mode;
          unique case (dec.act)
            usb_ep_pkg::ACT_IGNORE: begin
            end
            usb_ep_pkg::ACT_NAK, usb_ep_pkg::ACT_STALL: begin
              resp_v_d = 1'b1;
              resp_k_d = (dec.act == usb_ep_pkg::ACT_NAK) ? usb_ep_pkg::HS_NAK : usb_ep_pkg::HS_STALL;
              done = 1'b1;
            end
            usb_ep_pkg::ACT_TX_ZERO, usb_ep_pkg::ACT_TX_COUNT: begin
              resp_v_d = 1'b1;
              resp_k_d = usb_ep_pkg::HS_DATA;
              resp_len_d = (dec.act == usb_ep_pkg::ACT_TX_ZERO) ? 4'h0 : count_q[TOKEN_EP_IN];
              // Isochronous In gets no host handshake, so it ends here
              if (dec.mode == usb_ep_pkg::MODE_ISO_IN) begin
                done = 1'b1;
              end else begin
                st_d = usb_ep_pkg::ST_TX_WAIT;
              end
            end
            default: st_d = usb_ep_pkg::ST_RX_DATA;
          endcase
        end
      end
      usb_ep_pkg::ST_RX_DATA: begin
        if (TIMEOUT_IN) begin
          st_d = usb_ep_pkg::ST_IDLE;
        end else begin
          if (DATA_START_IN && pid_q == usb_ep_pkg::PID_SETUP) begin
            flags_d[ep_q] = 3'b001 << usb_ep_pkg::FLAG_SETUP;
          end
          if (DATA_DONE_IN) begin
            st_d = usb_ep_pkg::ST_IDLE;
            if (rx_ok) begin
              count_d[ep_q] = DATA_COUNT_IN;
              done = 1'b1;
              resp_v_d = (act_q != usb_ep_pkg::ACT_ALWAYS);
              unique case (act_q)
                usb_ep_pkg::ACT_ACCEPT: begin
                  resp_k_d = usb_ep_pkg::HS_ACK;
                  mode_d[ep_q] = usb_ep_pkg::MODE_NAK_BOTH;
                  ack_xfer = 1'b1;
                end
                usb_ep_pkg::ACT_ACK: begin
                  resp_k_d = usb_ep_pkg::HS_ACK;
                  mode_d[ep_q] = next_q;
                  ack_xfer = 1'b1;
                end
                usb_ep_pkg::ACT_CHECK: begin
                  if (DATA_COUNT_IN == usb_ep_pkg::ZERO_LEN_RX && DATA_TOGGLE_IN) begin
                    resp_k_d = usb_ep_pkg::HS_ACK;
                    ack_xfer = 1'b1;
                  end else begin
                    resp_k_d = usb_ep_pkg::HS_STALL;
                  end
                end
                usb_ep_pkg::ACT_NAK: resp_k_d = usb_ep_pkg::HS_NAK;
                usb_ep_pkg::ACT_STALL: resp_k_d = usb_ep_pkg::HS_STALL;
                default: resp_k_d = usb_ep_pkg::HS_NONE;
              endcase
            end
          end
        end
      end
      usb_ep_pkg::ST_TX_WAIT: begin
        if (TIMEOUT_IN) begin
          st_d = usb_ep_pkg::ST_IDLE;
        end else if (HOST_ACK_IN) begin
          st_d = usb_ep_pkg::ST_IDLE;
          mode_d[ep_q] = next_q;
          done = 1'b1;
          ack_xfer = 1'b1;
        end
      end
      default: st_d = usb_ep_pkg::ST_IDLE;
    endcase
    if (done) begin
      irq_d[ev_ep] = 1'b1;
      if (pid_d != usb_ep_pkg::PID_SETUP) begin
        flags_d[ev_ep] = (pid_d == usb_ep_pkg::PID_IN) ? (3'b001 << usb_ep_pkg::FLAG_IN)
                                                      : (3'b001 << usb_ep_pkg::FLAG_OUT);
      end
    end
    if (BUF_CORRUPT_IN) begin
      irq_d[ep_q] = 1'b1;
    end
    // Placed after the read so a new lock wins over a same-cycle unlock
    if (ack_xfer && ev_ep == usb_ep_pkg::LOCK_EP) begin
      lock_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      st_q <= usb_ep_pkg::ST_IDLE;
      ep_q <= 2'h0;
      pid_q <= usb_ep_pkg::PID_SETUP;
      act_q <= usb_ep_pkg::ACT_IGNORE;
      next_q <= usb_ep_pkg::MODE_DISABLED;
      for (int i = 0; i < usb_ep_pkg::NUM_EP; i++) begin
        mode_q[i] <= usb_ep_pkg::MODE_DISABLED;
        count_q[i] <= usb_ep_pkg::COUNT_RST;
        flags_q[i] <= usb_ep_pkg::FLAGS_RST;
      end
      lock_q <= 1'b0;
      resp_v_q <= 1'b0;
      resp_k_q <= usb_ep_pkg::HS_NONE;
      resp_len_q <= usb_ep_pkg::COUNT_RST;
      rd_mode_q <= usb_ep_pkg::MODE_DISABLED;
      rd_count_q <= usb_ep_pkg::COUNT_RST;
      irq_q <= 3'h0;
    end else begin
      st_q <= st_d;
      ep_q <= ep_d;
      pid_q <= pid_d;
      act_q <= act_d;
      next_q <= next_d;
      mode_q <= mode_d;
      count_q <= count_d;
      flags_q <= flags_d;
      lock_q <= lock_d;
      resp_v_q <= resp_v_d;
      resp_k_q <= resp_k_d;
      resp_len_q <= resp_len_d;
      rd_mode_q <= rd_mode_d;
      rd_count_q <= rd_count_d;
      irq_q <= irq_d;
    end
  end

  assign RESP_VALID_OUT = resp_v_q;
  assign RESP_KIND_OUT = resp_k_q;
  assign RESP_LEN_OUT = resp_len_q;
  assign CPU_MODE_OUT = rd_mode_q;
  assign CPU_COUNT_OUT = rd_count_q;
  assign PID_FLAGS_OUT = {flags_q[2], flags_q[1], flags_q[0]};
  assign EP_IRQ_OUT = irq_q;
  assign EP0_LOCK_OUT = lock_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence tok_to(logic [3:0] m, logic [1:0] p);
    st_q == usb_ep_pkg::ST_IDLE && tok_ok && mode_q[TOKEN_EP_IN] == m && TOKEN_PID_IN == p;
  endsequence
  sequence rx_end(usb_ep_pkg::act_e a);
    st_q == usb_ep_pkg::ST_RX_DATA && !TIMEOUT_IN && DATA_DONE_IN && rx_ok && act_q == a;
  endsequence

  a_disabled_ignored: assert property (tok_to(usb_ep_pkg::MODE_DISABLED, TOKEN_PID_IN) |=>
    !RESP_VALID_OUT && st_q == usb_ep_pkg::ST_IDLE && EP_IRQ_OUT == 3'h0) else $error("disabled answered");
  a_nak_both_in: assert property (tok_to(usb_ep_pkg::MODE_NAK_BOTH, 2'h1) |=>
    RESP_VALID_OUT && RESP_KIND_OUT == usb_ep_pkg::HS_NAK) else $error("no NAK in 0001");
  a_stall_out: assert property (tok_to(usb_ep_pkg::MODE_STATUS_IN, 2'h2) |=>
    RESP_VALID_OUT && RESP_KIND_OUT == usb_ep_pkg::HS_STALL) else $error("0110 Out not stalled");
  a_iso_setup: assert property (tok_to(usb_ep_pkg::MODE_ISO_OUT, 2'h0) |=>
    st_q == usb_ep_pkg::ST_IDLE && !RESP_VALID_OUT) else $error("iso took Setup");
  a_ack_rewrite: assert property (rx_end(usb_ep_pkg::ACT_ACK) |=>
    mode_q[$past(ep_q)] == $past(next_q) && RESP_KIND_OUT == usb_ep_pkg::HS_ACK) else $error("no rewrite");
  a_in_rewrite: assert property (st_q == usb_ep_pkg::ST_TX_WAIT && HOST_ACK_IN && !TIMEOUT_IN
    && next_q == usb_ep_pkg::MODE_NAK_IN |=> mode_q[$past(ep_q)] == usb_ep_pkg::MODE_NAK_IN) else $error("no 1100");
  a_reset_mode: assert property (disable iff (1'b0) SYS_RST_IN |=>
    mode_q[0] == 4'h0 && mode_q[1] == 4'h0 && mode_q[2] == 4'h0) else $error("mode not reset");
  a_setup_nak: assert property (rx_end(usb_ep_pkg::ACT_ACCEPT) |=>
    mode_q[$past(ep_q)] == usb_ep_pkg::MODE_NAK_BOTH && RESP_KIND_OUT == usb_ep_pkg::HS_ACK) else $error("setup");
  a_bad_len: assert property (st_q == usb_ep_pkg::ST_RX_DATA && DATA_DONE_IN
    && DATA_COUNT_IN > 4'ha |=> !RESP_VALID_OUT && EP_IRQ_OUT == 3'h0) else $error("long packet answered");
  a_setup_flag: assert property (st_q == usb_ep_pkg::ST_RX_DATA && DATA_START_IN && !TIMEOUT_IN
    && pid_q == usb_ep_pkg::PID_SETUP |=> flags_q[$past(ep_q)] == 3'b001) else $error("setup flag late");
  a_lock_set: assert property (rx_end(usb_ep_pkg::ACT_ACCEPT) ##0 ep_q == 2'h0 |=>
    EP0_LOCK_OUT ##1 (EP0_LOCK_OUT || $past(CPU_RD_IN && CPU_EP_IN == 2'h0))) else $error("ep0 not locked");
  a_locked_wr: assert property (lock_q && CPU_EP_IN == 2'h0 && CPU_MODE_WR_IN && st_q == usb_ep_pkg::ST_IDLE
    && !tok_ok |=> $stable(mode_q[0])) else $error("locked write landed");

endmodule // usb_ep_responder

// [hdl/usb_ep_pkg.sv]
/*
  Shared constants and types for the endpoint mode responder.
  Assumes a single 125 MHz clock domain; no bus, all control is plain ports.
*/
package usb_ep_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_EP = 3;
  localparam logic [1:0] LOCK_EP = 2'h0;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_DISABLED = 4'h0;
  localparam logic [3:0] MODE_NAK_BOTH = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_BOTH = 4'h3;
  localparam logic [3:0] MODE_IGNORE_BOTH = 4'h4;
  localparam logic [3:0] MODE_ISO_OUT = 4'h5;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_ISO_IN = 4'h7;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_NAK_OUT_STIN = 4'ha;
  localparam logic [3:0] MODE_ACK_OUT_STIN = 4'hb;
  localparam logic [3:0] MODE_NAK_IN = 4'hc;
  localparam logic [3:0] MODE_ACK_IN = 4'hd;
  localparam logic [3:0] MODE_NAK_IN_STOUT = 4'he;
  localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hf;

  // ----------------------------------------------------------------
  // Packet limits, reset values, flag positions
  // ----------------------------------------------------------------
  localparam logic [3:0] MAX_RX_LEN = 4'ha;
  localparam logic [3:0] ZERO_LEN_RX = 4'h2;
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam int FLAG_SETUP = 0;
  localparam int FLAG_IN = 1;
  localparam int FLAG_OUT = 2;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PID_SETUP = 2'h0, PID_IN = 2'h1, PID_OUT = 2'h2} pid_e;
  typedef enum logic [3:0] {
    ACT_IGNORE = 4'h0, ACT_ACCEPT = 4'h1, ACT_NAK = 4'h2, ACT_STALL = 4'h3, ACT_TX_ZERO = 4'h4,
    ACT_TX_COUNT = 4'h5, ACT_ACK = 4'h6, ACT_CHECK = 4'h7, ACT_ALWAYS = 4'h8
  } act_e;
  typedef enum logic [2:0] {HS_NONE = 3'h0, HS_ACK = 3'h1, HS_NAK = 3'h2, HS_STALL = 3'h3, HS_DATA = 3'h4} resp_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RX_DATA = 2'b01, ST_TX_WAIT = 2'b11} state_e;

endpackage

// [hdl/ep_decode_if.sv]
/*
  Carrier between the responder and its mode decoder.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/10ps
interface ep_decode_if;
  logic [3:0] mode;
  usb_ep_pkg::pid_e pid;
  usb_ep_pkg::act_e act;
  logic [3:0] next_mode;
  modport requester (output mode, output pid, input act, input next_mode);
  modport decoder (input mode, input pid, output act, output next_mode);
endinterface

// [hdl/ep_mode_decoder.sv]
/*
  Combinational decode of an endpoint mode and token into an action and
  the mode to take after an ACK. Assumes the requester holds mode and pid stable.
*/
`timescale 1ns/10ps
module ep_mode_decoder (
  ep_decode_if.decoder dec
);

  // ----------------------------------------------------------------
  // Per-token pick
  // ----------------------------------------------------------------
  function automatic usb_ep_pkg::act_e pick(input usb_ep_pkg::pid_e pid, input usb_ep_pkg::act_e s,
                                            input usb_ep_pkg::act_e i, input usb_ep_pkg::act_e o);
    unique case (pid)
      usb_ep_pkg::PID_SETUP: pick = s;
      usb_ep_pkg::PID_IN: pick = i;
      default: pick = o;
    endcase
  endfunction

  always_comb begin
    dec.next_mode = dec.mode;
    unique case (dec.mode)
      usb_ep_pkg::MODE_DISABLED:
        dec.act = usb_ep_pkg::ACT_IGNORE;
      usb_ep_pkg::MODE_NAK_BOTH:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_NAK, usb_ep_pkg::ACT_NAK);
      usb_ep_pkg::MODE_STATUS_OUT:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_STALL, usb_ep_pkg::ACT_CHECK);
      usb_ep_pkg::MODE_STALL_BOTH:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_STALL, usb_ep_pkg::ACT_STALL);
      usb_ep_pkg::MODE_IGNORE_BOTH:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_IGNORE);
      usb_ep_pkg::MODE_ISO_OUT:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_ALWAYS);
      usb_ep_pkg::MODE_STATUS_IN:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_TX_ZERO, usb_ep_pkg::ACT_STALL);
      usb_ep_pkg::MODE_ISO_IN:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_TX_COUNT, usb_ep_pkg::ACT_IGNORE);
      usb_ep_pkg::MODE_NAK_OUT:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_NAK);
      usb_ep_pkg::MODE_ACK_OUT: begin
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_ACK);
        dec.next_mode = usb_ep_pkg::MODE_NAK_OUT;
      end
      usb_ep_pkg::MODE_NAK_OUT_STIN:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_TX_ZERO, usb_ep_pkg::ACT_NAK);
      usb_ep_pkg::MODE_ACK_OUT_STIN: begin
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_TX_ZERO, usb_ep_pkg::ACT_ACK);
        if (dec.pid == usb_ep_pkg::PID_OUT) begin
          dec.next_mode = usb_ep_pkg::MODE_NAK_OUT_STIN;
        end
      end
      usb_ep_pkg::MODE_NAK_IN:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_NAK, usb_ep_pkg::ACT_IGNORE);
      usb_ep_pkg::MODE_ACK_IN: begin
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_IGNORE, usb_ep_pkg::ACT_TX_COUNT, usb_ep_pkg::ACT_IGNORE);
        dec.next_mode = usb_ep_pkg::MODE_NAK_IN;
      end
      usb_ep_pkg::MODE_NAK_IN_STOUT:
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_NAK, usb_ep_pkg::ACT_CHECK);
      default: begin
        dec.act = pick(dec.pid, usb_ep_pkg::ACT_ACCEPT, usb_ep_pkg::ACT_TX_COUNT, usb_ep_pkg::ACT_CHECK);
        if (dec.pid == usb_ep_pkg::PID_IN) begin
          dec.next_mode = usb_ep_pkg::MODE_NAK_IN_STOUT;
        end
      end
    endcase
  end

endmodule // ep_mode_decoder

// [bench/usb_host_model.sv]
/*
  Upstream host model: tokens, data packet phases and host handshakes.
  Assumes the responder samples every strobe on the rising edge of clk_in.
*/
`timescale 1ns/10ps
module usb_host_model (
  input wire logic clk_in,
  output logic tok_v_out,
  output logic [1:0] tok_pid_out,
  output logic [1:0] tok_ep_out,
  output logic start_out,
  output logic done_out,
  output logic [3:0] cnt_out,
  output logic tog_out,
  output logic err_out,
  output logic ack_out,
  output logic tmo_out
);
  initial begin
    {tok_v_out, done_out, start_out, ack_out, tmo_out, tog_out, err_out} = 7'h00;
    {tok_pid_out, tok_ep_out, cnt_out} = 8'h00;
  end
  // Unqualified fields are scrambled so a stale value can never pass for a real one
  task automatic token(input logic [1:0] ep, input logic [1:0] pid);
    tok_v_out <= 1'b1;
    tok_pid_out <= pid;
    tok_ep_out <= ep;
    @(posedge clk_in);
    tok_v_out <= 1'b0;
    tok_pid_out <= ~pid;
    tok_ep_out <= ~ep;
  endtask
  task automatic done(input logic [3:0] c, input logic t, input logic e);
    done_out <= 1'b1;
    cnt_out <= c;
    tog_out <= t;
    err_out <= e;
    @(posedge clk_in);
    done_out <= 1'b0;
    cnt_out <= ~c;
    tog_out <= ~t;
    err_out <= ~e;
  endtask
  // Select bits: start of data phase, host ACK, abort
  task automatic pulse(input logic [2:0] sel);
    {start_out, ack_out, tmo_out} <= sel;
    @(posedge clk_in);
    {start_out, ack_out, tmo_out} <= 3'h0;
  endtask
endmodule // usb_host_model

// [bench/testbench.sv]
/*
  Self-checking bench for the endpoint mode responder.
  Assumes the host model drives the token side and this bench the CPU side.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cpu_ep = 2'h0;
  logic mode_wr = 1'b0;
  logic count_wr = 1'b0;
  logic rd = 1'b0;
  logic corrupt = 1'b0;
  logic clr = 1'b1;
  logic [3:0] wdata = 4'h0;
  logic tok_v, start, done, tog, err, hack, tmo, resp_v, lock;
  logic [1:0] tok_pid, tok_ep;
  logic [2:0] kind, irq, seen_irq, seen_kind;
  logic [3:0] cnt, len, seen_len, mode_rd, count_rd;
  logic [8:0] flags;
  logic [15:0] r;
  int mismatches = 0;
  int samples_checked = 0;
  // Row: mode, {pid, host ack, bad length}, expected kind, expected mode after
  logic [15:0] rows [36] = '{16'h0000, 16'h0400, 16'h0800, 16'h1011, 16'h1421, 16'h1821, 16'h2432, 16'h2812,
    16'h2932, 16'h2011, 16'h3433, 16'h3833, 16'h4404, 16'h4804, 16'h4011, 16'h5005, 16'h5405, 16'h5805,
    16'h6646, 16'h6836, 16'h7447, 16'h7007, 16'h8828, 16'h8408, 16'h9818, 16'h9009, 16'ha82a, 16'ha64a,
    16'hb81a, 16'hb011, 16'hc42c, 16'hc80c, 16'hd64c, 16'he42e, 16'he81e, 16'hf64e};
  always #4 clk = ~clk;
  usb_host_model u_usb_host_model (.clk_in(clk), .tok_v_out(tok_v), .tok_pid_out(tok_pid), .tok_ep_out(tok_ep),
    .start_out(start), .done_out(done), .cnt_out(cnt), .tog_out(tog), .err_out(err), .ack_out(hack), .tmo_out(tmo));
  usb_ep_responder u_usb_ep_responder (.CLK_IN(clk), .SYS_RST_IN(rst), .TOKEN_VALID_IN(tok_v),
    .TOKEN_PID_IN(tok_pid), .TOKEN_EP_IN(tok_ep), .DATA_START_IN(start), .DATA_DONE_IN(done),
    .DATA_COUNT_IN(cnt), .DATA_TOGGLE_IN(tog), .DATA_ERR_IN(err), .HOST_ACK_IN(hack), .TIMEOUT_IN(tmo),
    .BUF_CORRUPT_IN(corrupt), .CPU_EP_IN(cpu_ep), .CPU_MODE_WR_IN(mode_wr), .CPU_COUNT_WR_IN(count_wr),
    .CPU_WDATA_IN(wdata), .CPU_RD_IN(rd), .RESP_VALID_OUT(resp_v), .RESP_KIND_OUT(kind), .RESP_LEN_OUT(len),
    .CPU_MODE_OUT(mode_rd), .CPU_COUNT_OUT(count_rd), .PID_FLAGS_OUT(flags), .EP_IRQ_OUT(irq),
    .EP0_LOCK_OUT(lock));
  // Responses and interrupts are one-cycle pulses, so they are caught here
  always @(posedge clk) begin
    if (clr) begin
      seen_irq <= 3'h0;
      seen_kind <= 3'h0;
    end else begin
      seen_irq <= seen_irq | irq;
      if (resp_v === 1'b1) begin
        seen_kind <= kind;
        seen_len <= len;
      end
    end
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Flags: write mode, write count, read
  task automatic cpu(input logic [1:0] ep, input logic [2:0] op, input logic [3:0] d);
    cpu_ep <= ep;
    {mode_wr, count_wr, rd} <= op;
    wdata <= d;
    @(posedge clk);
    {mode_wr, count_wr, rd} <= 3'h0;
    @(posedge clk);
  endtask
  // On Setup and Out, a asks for a DATA0 packet instead of DATA1
  task automatic xfer(input logic [1:0] ep, input logic [1:0] pid, input logic [3:0] c, input logic e,
                      input logic a);
    clr <= 1'b1;
    u_usb_host_model.token(ep, pid);
    clr <= 1'b0;
    if (pid == 2'h1) begin
      repeat (2) @(posedge clk);
      if (a) u_usb_host_model.pulse(3'h2);
    end else begin
      u_usb_host_model.pulse(3'h4);
      u_usb_host_model.done(c, !a, e);
    end
    repeat (3) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cpu(2'h0, 3'h1, 4'h0);
    check({mode_rd, count_rd, lock, flags}, 18'h0);
    $display("reset test done");
    for (int i = 0; i < 36; i++) begin
      r = rows[i];
      cpu(2'h1, 3'h4, r[15:12]);
      cpu(2'h1, 3'h2, 4'h5);
      xfer(2'h1, r[11:10], (r[11:10] == 2'h0) ? 4'ha : (r[8] ? 4'h3 : 4'h2), 1'b0, r[9]);
      check(seen_kind, r[6:4]);
      if (r[6:4] == 3'h4) check(seen_len, (r[15:12] inside {4'h6, 4'ha, 4'hb}) ? 4'h0 : 4'h5);
      cpu(2'h1, 3'h1, 4'h0);
      check(mode_rd, r[3:0]);
    end
    $display("mode table test done");
    cpu(2'h1, 3'h4, 4'h9);
    xfer(2'h1, 2'h2, 4'hb, 1'b0, 1'b0);
    check({seen_irq, seen_kind}, 6'h0);
    xfer(2'h1, 2'h2, 4'h2, 1'b1, 1'b0);
    check({seen_irq, seen_kind}, 6'h0);
    cpu(2'h1, 3'h4, 4'hd);
    xfer(2'h1, 2'h1, 4'h0, 1'b0, 1'b0);
    u_usb_host_model.pulse(3'h1);
    cpu(2'h1, 3'h1, 4'h0);
    check({mode_rd, count_rd}, 8'hd5);
    cpu(2'h1, 3'h4, 4'he);
    xfer(2'h1, 2'h2, 4'h2, 1'b0, 1'b1);
    check({seen_kind, flags[5:3]}, 6'h1c);
    $display("invalid packet test done");
    cpu(2'h0, 3'h4, 4'h2);
    clr <= 1'b1;
    u_usb_host_model.token(2'h0, 2'h0);
    clr <= 1'b0;
    u_usb_host_model.pulse(3'h4);
    repeat (2) @(posedge clk);
    check(flags[2:0], 3'h1);
    u_usb_host_model.done(4'ha, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    check({seen_irq, seen_kind, lock}, 7'h13);
    cpu(2'h0, 3'h6, 4'h3);
    cpu(2'h0, 3'h1, 4'h0);
    check({mode_rd, count_rd, lock}, 9'h034);
    cpu(2'h0, 3'h4, 4'h3);
    xfer(2'h0, 2'h1, 4'h0, 1'b0, 1'b0);
    check({seen_kind, flags[2:0]}, 6'h1a);
    $display("endpoint zero test done");
    cpu(2'h2, 3'h4, 4'h1);
    xfer(2'h2, 2'h1, 4'h0, 1'b0, 1'b0);
    clr <= 1'b1;
    corrupt <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    corrupt <= 1'b0;
    repeat (3) @(posedge clk);
    check(seen_irq, 3'h4);
    $display("buffer fault test done");
    close_out();
  end
endmodule // testbench
